// ==== hdl/sra_slave.sv ====
// Serial register access slave: four-wire port with clock phase set at select.
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Slave only; every frame starts when the master pulls select low.
// - Frame is a header byte: command bit, 7 address bits, then data bytes.
// - Command bit 0 writes following bytes; 1 returns register contents.
// - Address increments by one for each further byte, reading or writing.
// - Clock low at select fall: launch on rising, capture on falling edge.
// - Clock high at select fall: launch on falling, capture on rising edge.
// - Only a select falling edge changes the chosen launch and capture edges.
// - Master drives each write bit on transfer edge; slave samples next edge.
// - Read: master sends command one and address; slave returns bytes MSB first.
// - In read data the slave drives on transfer edge; master samples next.
// - At end of a read the data output is released to high impedance.
module sra_slave
   import sra_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe_n,
   output logic o_wr_valid,
   input wire logic i_wr_ready,
   output logic [6:0] o_wr_addr,
   output logic [7:0] o_wr_data,
   output logic o_rd_req,
   output logic [6:0] o_rd_addr,
   input wire logic [7:0] i_rd_data,
   output logic o_busy
);

   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.
   // The three serial pins come from the master's clock domain and pass two flops each.
   // They share one synchroniser, so data and clock keep their relative timing.
   // Each pin edge is seen two to three system clocks late, about 24 ns at most.
   // The serial half period must stay well above that delay.
   // The highest serial bit rate of the link still leaves a wide margin here.
   // Nothing but the synchroniser's second stage is read by the logic below.
   // A pin that moves during reset is simply seen at its new level afterwards.

   logic [2:0] pins_sync;
   logic sclk_s;
   logic cs_n_s;
   logic mosi_s;

   sra_sync #(
      .WIDTH(3)
   ) u_sync (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_async({i_sclk, i_cs_n, i_mosi}),
      .o_sync(pins_sync)
   );

   assign sclk_s = pins_sync[2];
   assign cs_n_s = pins_sync[1];
   assign mosi_s = pins_sync[0];

   //////////////////////////////////////////////////////////////////////////
   // Edge detection on synchronised pins.
   // Each edge pulse lasts one system clock and drives at most one shift or count step.

   logic sclk_d_reg;
   logic cs_n_d_reg;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;

   // Previous levels for edge finding.
   // Both reset high like the synchroniser, so no false rise appears after reset.
   // A clock pin that idles low then shows one fall, which is harmless because
   // select is still high at that time.
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         sclk_d_reg <= 1'b1;
         cs_n_d_reg <= 1'b1;
      end else begin
         sclk_d_reg <= sclk_s;
         cs_n_d_reg <= cs_n_s;
      end
   end

   assign sclk_rise = sclk_s && !sclk_d_reg;
   assign sclk_fall = !sclk_s && sclk_d_reg;
   assign cs_fall = !cs_n_s && cs_n_d_reg;
   assign cs_rise = cs_n_s && !cs_n_d_reg;

   //////////////////////////////////////////////////////////////////////////
   // Phase selection and frame sequencing.
   // Select fall latches the clock level as the phase of the frame.
   // Nothing else may change it until the next select fall, so a clock glitch
   // between frames cannot move the sampling edge.
   // The read path loads the data at the end of the same cycle as the address request, so
   // the register file must answer combinationally within that cycle.
   // Only the read data section drives the data pin; the header leaves it released.

   sra_state_t state_reg;
   sra_state_t state_next;
   logic cap_on_rise_reg;
   logic cap_on_rise_next;
   logic [2:0] bit_cnt_reg;
   logic [2:0] bit_cnt_next;
   logic [7:0] shift_in_reg;
   logic [7:0] shift_in_next;
   logic [7:0] shift_out_reg;
   logic [7:0] shift_out_next;
   logic [6:0] addr_reg;
   logic [6:0] addr_next;
   logic miso_reg;
   logic miso_next;
   logic oe_n_reg;
   logic oe_n_next;
   logic rd_req_reg;
   logic rd_req_next;
   logic load_pend_reg;
   logic load_pend_next;
   logic cap_edge;
   logic launch_edge;
   logic [7:0] byte_in;
   logic fifo_in_valid;
   logic fifo_in_ready;
   sra_wr_t fifo_in_word;
   sra_wr_t fifo_out_word;

   // Increment of the register address, wrapping at seven bits.
   function automatic logic [6:0] addr_inc(input logic [6:0] a);
      addr_inc = 7'(a + 7'h01);
   endfunction

   // Command field of a header byte: true when the master asks for a read.
   function automatic logic hdr_is_read(input logic [7:0] b);
      hdr_is_read = (b[7] == SRA_CMD_READ);
   endfunction

   // Register address field of a header byte.
   function automatic logic [6:0] hdr_addr(input logic [7:0] b);
      hdr_addr = b[6:0];
   endfunction

   // Capture and launch edges follow the phase latched at select fall.
   // Each serial period has one launch and one capture, half a period apart.
   assign cap_edge = cap_on_rise_reg ? sclk_rise : sclk_fall;
   assign launch_edge = cap_on_rise_reg ? sclk_fall : sclk_rise;
   assign byte_in = {shift_in_reg[6:0], mosi_s};

   // Next-state logic of the frame sequencer.
   // Priority: a select fall starts a frame, a high select ends it, and only inside
   // a frame do clock edges shift data. A frame cut in mid-byte thus loses that byte,
   // and the next frame always begins with a header.
   always_comb begin
      state_next = state_reg;
      cap_on_rise_next = cap_on_rise_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_in_next = shift_in_reg;
      shift_out_next = shift_out_reg;
      addr_next = addr_reg;
      miso_next = miso_reg;
      oe_n_next = oe_n_reg;
      rd_req_next = 1'b0;
      load_pend_next = load_pend_reg;
      fifo_in_valid = 1'b0;
      fifo_in_word = '{addr: addr_reg, data: byte_in};
      if (cs_fall) begin
         state_next = SRA_ST_HEADER;
         cap_on_rise_next = sclk_s;
         bit_cnt_next = SRA_BIT_CNT_RST;
         shift_in_next = SRA_BYTE_RST;
      end else if (cs_rise || cs_n_s) begin
         // The bit counter returns to zero so that the next frame starts byte aligned.
         // Frame end drops partial byte.
         state_next = SRA_ST_IDLE;
         bit_cnt_next = SRA_BIT_CNT_RST;
         shift_in_next = SRA_BYTE_RST;
         load_pend_next = 1'b0;
         oe_n_next = 1'b1;
         miso_next = 1'b0;
      end else begin
         if (load_pend_reg) begin
            // Read data is loaded at the end of the cycle in which the request is high.
            // The first launch edge of the byte comes much later than this load, since
            // the master still has half a serial period to run.
            shift_out_next = i_rd_data;
            load_pend_next = 1'b0;
         end
         // The bit leaves half a serial period before the master samples it.
         // Drive read bits on launch edge.
         if (launch_edge && state_reg == SRA_ST_RDATA) begin
            oe_n_next = 1'b0;
            miso_next = shift_out_reg[7];
            shift_out_next = {shift_out_reg[6:0], 1'b0};
         end
         if (cap_edge && state_reg != SRA_ST_IDLE) begin
            shift_in_next = byte_in;
            bit_cnt_next = 3'(bit_cnt_reg + 3'h1);
            if (bit_cnt_reg == SRA_BIT_CNT_LAST) begin
               unique case (state_reg)
                  SRA_ST_HEADER: begin
                     // The header fixes the direction for the rest of the frame.
                     // Decode command and address.
                     addr_next = hdr_addr(byte_in);
                     if (hdr_is_read(byte_in)) begin
                        state_next = SRA_ST_RDATA;
                        rd_req_next = 1'b1;
                        load_pend_next = 1'b1;
                     end else begin
                        state_next = SRA_ST_WDATA;
                     end
                  end
                  SRA_ST_WDATA: begin
                     // A byte that meets a full buffer is lost; busy warns the local side.
                     // Write byte then advance address.
                     fifo_in_valid = 1'b1;
                     addr_next = addr_inc(addr_reg);
                  end
                  SRA_ST_RDATA: begin
                     // The next byte is fetched as soon as the current one is captured.
                     // Next read address.
                     addr_next = addr_inc(addr_reg);
                     rd_req_next = 1'b1;
                     load_pend_next = 1'b1;
                  end
                  default: begin
                     state_next = SRA_ST_IDLE;
                  end
               endcase
            end
         end
      end
   end

   // Registers of the frame sequencer.
   // This process only holds state; every decision is made in the process above.
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         state_reg <= SRA_ST_IDLE;
         cap_on_rise_reg <= 1'b0;
         bit_cnt_reg <= SRA_BIT_CNT_RST;
         shift_in_reg <= SRA_BYTE_RST;
         shift_out_reg <= SRA_BYTE_RST;
         addr_reg <= SRA_ADDR_RST;
         miso_reg <= 1'b0;
         oe_n_reg <= 1'b1;
         rd_req_reg <= 1'b0;
         load_pend_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cap_on_rise_reg <= cap_on_rise_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_in_reg <= shift_in_next;
         shift_out_reg <= shift_out_next;
         addr_reg <= addr_next;
         miso_reg <= miso_next;
         oe_n_reg <= oe_n_next;
         rd_req_reg <= rd_req_next;
         load_pend_reg <= load_pend_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Write buffer towards the register file.
   // Received writes queue here so that the register file may stall for a while.
   // Four entries cover a stall of several serial bytes; beyond that writes are lost.

   sra_fifo #(
      .WIDTH(SRA_ADDR_W + SRA_DATA_W),
      .DEPTH(SRA_FIFO_DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(fifo_in_valid),
      .o_in_ready(fifo_in_ready),
      .i_in_data(fifo_in_word),
      .o_out_valid(o_wr_valid),
      .i_out_ready(i_wr_ready),
      .o_out_data(fifo_out_word)
   );

   // Outputs; read address is the live register address.
   // The data pin and its enable come straight from flops, so the pin never glitches.
   assign o_wr_addr = fifo_out_word.addr;
   assign o_wr_data = fifo_out_word.data;
   assign o_rd_req = rd_req_reg;
   assign o_rd_addr = addr_reg;
   assign o_miso = miso_reg;
   assign o_miso_oe_n = oe_n_reg;
   // Busy while a frame runs or the write buffer is full.
   assign o_busy = (state_reg != SRA_ST_IDLE) || !fifo_in_ready;

endmodule

// ==== hdl/sra_pkg.sv ====
// Package of constants and types for the serial register access slave.
package sra_pkg;

   localparam int SRA_ADDR_W = 7;
   localparam int SRA_DATA_W = 8;
   localparam int SRA_BITS_PER_BYTE = 8;
   localparam int SRA_FIFO_DEPTH = 4;
   localparam logic SRA_CMD_WRITE = 1'b0;
   localparam logic SRA_CMD_READ = 1'b1;
   localparam logic [2:0] SRA_BIT_CNT_RST = 3'h0;
   localparam logic [2:0] SRA_BIT_CNT_LAST = 3'h7;
   localparam logic [6:0] SRA_ADDR_RST = 7'h00;
   localparam logic [7:0] SRA_BYTE_RST = 8'h00;

   // Timing of the serial link, in ns, and the clock rate.
   localparam int SRA_MCLK_PERIOD_NS = 8;
   localparam int SRA_DOD_MAX_NS = 80;
   localparam int SRA_DOHZ_MAX_NS = 80;
   // Longest delays round down to whole cycles.
   localparam int SRA_DOD_CYC = SRA_DOD_MAX_NS / SRA_MCLK_PERIOD_NS;
   localparam int SRA_DOHZ_CYC = SRA_DOHZ_MAX_NS / SRA_MCLK_PERIOD_NS;

   // A register write leaving the serial port.
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] data;
   } sra_wr_t;

   // Frame sequencing states, Gray coded from idle through header to write data.
   typedef enum logic [1:0] {
      SRA_ST_IDLE = 2'b00,
      SRA_ST_HEADER = 2'b01,
      SRA_ST_WDATA = 2'b11,
      SRA_ST_RDATA = 2'b10
   } sra_state_t;

endpackage

// ==== hdl/sra_sync.sv ====
// Two-flop synchroniser for the serial pins.
`timescale 1ns/10ps
module sra_sync
   import sra_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // The first stage feeds the second only.
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         stage1_reg <= '1;
         stage2_reg <= '1;
      end else begin
         stage1_reg <= i_async;
         stage2_reg <= stage1_reg;
      end
   end

   assign o_sync = stage2_reg;

endmodule

// ==== hdl/sra_fifo.sv ====
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module sra_fifo
   import sra_pkg::*;
#(
   parameter int WIDTH = 15,
   parameter int DEPTH = 4
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] wr_ptr_next;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW-1:0] rd_ptr_next;
   logic [PW:0] count_reg;
   logic [PW:0] count_next;
   logic push;
   logic pop;

   // Honest full and empty come from the fill count.
   assign o_in_ready = (count_reg != PW'(0) + (PW+1)'(DEPTH));
   assign o_out_valid = (count_reg != '0);
   assign o_out_data = mem_reg[rd_ptr_reg];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   // Pointer and count arithmetic.
   always_comb begin
      wr_ptr_next = push ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
      rd_ptr_next = pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
      count_next = count_reg;
      if (push && !pop) begin
         count_next = (PW+1)'(count_reg + 1'b1);
      end else if (pop && !push) begin
         count_next = (PW+1)'(count_reg - 1'b1);
      end
   end

   // State registers and storage.
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
      end
      if (push) begin
         mem_reg[wr_ptr_reg] <= i_in_data;
      end
   end

endmodule

// ==== test/sra_slave_props.sv ====
// Concurrent checks on the ports of the serial register access slave.
`timescale 1ns/10ps
module sra_slave_props
   import sra_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   input wire logic o_miso,
   input wire logic o_miso_oe_n,
   input wire logic o_wr_valid,
   input wire logic i_wr_ready,
   input wire logic [6:0] o_wr_addr,
   input wire logic [7:0] o_wr_data,
   input wire logic o_rd_req,
   input wire logic [6:0] o_rd_addr,
   input wire logic [7:0] i_rd_data,
   input wire logic o_busy
);
   logic rdf_reg, rdf_next;
   logic [6:0] la_reg, la_next;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   // Remembers the last read address while the select pin stays low.
   always_comb begin
      rdf_next = rdf_reg;
      la_next = la_reg;
      if (o_rd_req) begin
         rdf_next = 1'b1;
         la_next = o_rd_addr;
      end
      if (i_cs_n) begin
         rdf_next = 1'b0;
      end
   end

   // Registers the tracking state.
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         rdf_reg <= 1'b0;
         la_reg <= SRA_ADDR_RST;
      end else begin
         rdf_reg <= rdf_next;
         la_reg <= la_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slave never initiates.
   a_req_in_frame: assert property (o_rd_req |-> !$past(i_cs_n, 6))
      else $error("read request outside a frame");
   a_rd_pulse: assert property (o_rd_req |=> !o_rd_req)
      else $error("read request longer than one cycle");
   a_rd_inc: assert property (o_rd_req && rdf_reg |-> o_rd_addr == la_reg + 7'h01)
      else $error("read address did not step by one");
   a_miso_steady: assert property ((!i_cs_n && $stable(i_sclk)) [*8] |-> o_miso_oe_n || $stable(o_miso))
      else $error("data output changed without a clock edge");
   a_oe_idle: assert property (i_cs_n [*8] |-> o_miso_oe_n)
      else $error("data output driven outside a frame");
   a_oe_after_req: assert property ($fell(o_miso_oe_n) |-> rdf_reg)
      else $error("data output driven before a read request");
   a_busy_frame: assert property ($fell(i_cs_n) ##1 !i_cs_n [*5] |-> o_busy)
      else $error("busy low during a frame");
   a_wr_hold: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable({o_wr_addr, o_wr_data}))
      else $error("write word changed while stalled");

   cover property (o_rd_req && rdf_reg);
   cover property ($fell(o_miso_oe_n));
   cover property (o_wr_valid && !i_wr_ready && o_busy);
endmodule

bind sra_slave sra_slave_props u_sra_slave_props (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sclk(i_sclk),
   .i_cs_n(i_cs_n), .i_mosi(i_mosi), .o_miso(o_miso), .o_miso_oe_n(o_miso_oe_n), .o_wr_valid(o_wr_valid),
   .i_wr_ready(i_wr_ready), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_rd_req(o_rd_req),
   .o_rd_addr(o_rd_addr), .i_rd_data(i_rd_data), .o_busy(o_busy));

// ==== test/sra_master_model.sv ====
// Behavioural serial master that frames transfers for the slave.
`timescale 1ns/10ps
module sra_master_model
   import sra_pkg::*;
(
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_mosi,
   input wire logic i_miso
);
   logic idle_hi;

   // Idle levels; the clock stands still outside frames.
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
      idle_hi = 1'b0;
   end

   // Clock level at select fall picks the phase.
   task automatic start(input logic hi);
      idle_hi = hi;
      o_sclk = hi;
      #100;
      o_cs_n = 1'b0;
      #100;
   endtask

   // Sends bits most significant first and samples returned data.
   task automatic xbits(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i >= 8 - n; i--) begin
         o_sclk = ~idle_hi;
         o_mosi = tx[i];
         #62.5;
         o_sclk = idle_hi;
         rx[i] = i_miso;
         #62.5;
      end
   endtask

   // Select rises only when no more bytes are wanted.
   task automatic stop();
      #100;
      o_cs_n = 1'b1;
      o_mosi = ~o_mosi;
      #300;
   endtask
endmodule

// ==== test/tb.sv ====
// Self-checking testbench for the serial register access slave.
`timescale 1ns/10ps
module tb
   import sra_pkg::*;
;
   logic i_mclk, i_sys_rst, i_sclk, i_cs_n, i_mosi, i_wr_ready;
   logic o_miso, o_miso_oe_n, o_wr_valid, o_rd_req, o_busy, miso_line;
   logic [6:0] o_wr_addr, o_rd_addr;
   logic [7:0] o_wr_data, i_rd_data, rx;
   logic [7:0] regs [128];
   sra_wr_t got [$];
   int fails, total_checks;

   sra_slave u_sra_slave (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
      .i_mosi(i_mosi), .o_miso(o_miso), .o_miso_oe_n(o_miso_oe_n), .o_wr_valid(o_wr_valid),
      .i_wr_ready(i_wr_ready), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_rd_req(o_rd_req),
      .o_rd_addr(o_rd_addr), .i_rd_data(i_rd_data), .o_busy(o_busy));
   sra_master_model u_sra_master_model (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_mosi(i_mosi), .i_miso(miso_line));

   // Clock, data line level and register file read.
   initial i_mclk = 1'b0;
   always #4 i_mclk = ~i_mclk;
   assign miso_line = o_miso_oe_n ? 1'bz : o_miso;
   assign i_rd_data = regs[o_rd_addr];

   // Collects every write word the slave hands over.
   always @(posedge i_mclk) begin
      if (o_wr_valid === 1'b1 && i_wr_ready === 1'b1) begin
         got.push_back({o_wr_addr, o_wr_data});
      end
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] act);
      total_checks++;
      if (act !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, act);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Burst write across the address wrap with the consumer stalled until the buffer refuses.
   task automatic t_write_fill();
      @(negedge i_mclk) i_wr_ready = 1'b0;
      u_sra_master_model.start(1'b0);
      u_sra_master_model.xbits({SRA_CMD_WRITE, 7'h7E}, 8, rx);
      for (int i = 0; i < 5; i++) u_sra_master_model.xbits(8'hA0 + 8'(i), 8, rx);
      u_sra_master_model.stop();
      chk("busy when full", 16'h0001, {15'h0, o_busy});
      @(negedge i_mclk) i_wr_ready = 1'b1;
      repeat (10) @(negedge i_mclk);
      chk("write count", 16'h0004, 16'(got.size()));
      for (int i = 0; i < 4; i++) chk("write word", {1'b0, 7'h7E + 7'(i), 8'hA0 + 8'(i)}, {1'b0, got[i]});
      got.delete();
   endtask

   // Burst read of three registers in the chosen clock phase.
   task automatic t_read(input logic hi);
      for (int i = 0; i < 3; i++) regs[16 + i] = 8'h5C ^ 8'(i * 37 + 2 * hi);
      u_sra_master_model.start(hi);
      u_sra_master_model.xbits({SRA_CMD_READ, 7'h10}, 8, rx);
      for (int i = 0; i < 3; i++) begin
         u_sra_master_model.xbits(8'hFF, 8, rx);
         chk("read byte", {8'h00, regs[16 + i]}, {8'h00, rx});
      end
      u_sra_master_model.stop();
      chk("output released", 16'h0001, {15'h0, o_miso_oe_n});
   endtask

   // Frame cut mid-byte, then a new frame in the other phase writes one byte.
   task automatic t_partial();
      u_sra_master_model.start(1'b1);
      u_sra_master_model.xbits({SRA_CMD_WRITE, 7'h20}, 8, rx);
      u_sra_master_model.xbits(8'h99, 4, rx);
      u_sra_master_model.stop();
      u_sra_master_model.start(1'b0);
      u_sra_master_model.xbits({SRA_CMD_WRITE, 7'h30}, 8, rx);
      u_sra_master_model.xbits(8'hA5, 8, rx);
      u_sra_master_model.stop();
      repeat (10) @(negedge i_mclk);
      chk("partial count", 16'h0001, 16'(got.size()));
      chk("new frame word", {1'b0, 7'h30, 8'hA5}, {1'b0, got[0]});
      got.delete();
   endtask

   // Stops a hung run well after the expected span of all scenarios.
   initial begin
      #200000;
      fails++;
      results();
   end

   // Reset, then the scenarios in order.
   initial begin
      i_sys_rst = 1'b1;
      i_wr_ready = 1'b1;
      fails = 0;
      total_checks = 0;
      for (int i = 0; i < 128; i++) regs[i] = 8'(i);
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk) i_sys_rst = 1'b0;
      repeat (6) @(negedge i_mclk);
      t_write_fill();
      t_read(1'b0);
      t_read(1'b1);
      t_partial();
      results();
   end
endmodule
